// [bench/tcwu_pin_src.sv]
`timescale 1ns/1ps
// event source standing on the timer 1 input pin
module tcwu_pin_src (
  input wire logic clk,        // processor clock
  input wire logic [1:0] mode, // 0 low, 1 high, 2 square
  output logic pin_q           // level on the pin
);
  logic ph_q; // square wave phase
  initial begin
    pin_q = 1'b0;
    ph_q = 1'b0;
  end
  // pin moves just after a rising edge; square wave has a 4-clock period
  always @(posedge clk) begin
    ph_q <= ~ph_q;
    case (mode)
      2'h0: pin_q <= 1'b0;
      2'h1: pin_q <= 1'b1;
      default: pin_q <= ph_q ? ~pin_q : pin_q;
    endcase
  end
endmodule

// [bench/tcwu_top_test.sv]
`timescale 1ns/1ps
`include "tcwu_defines.svh"
module tcwu_top_test;
  // one register row: written value and what reads back
  typedef struct packed {
    logic [9:0] idx;
    logic [15:0] wd;
    logic [15:0] exp;
    logic err;
  } tcwu_row_s;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, pin, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic t1_irq, t2_irq, wd_irq, wave, wd_mask;
  logic [2:0] wd_rank;
  logic [1:0] pin_mode;
  int fail_count, n_compared, g, p, q, h;
  tcwu_row_s rows [10];

  tcwu_top u_dut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer1_input(pin), .timer1_wave_out(wave), .timer1_irq(t1_irq),
    .timer2_irq(t2_irq), .wdog_irq_req(wd_irq), .wdog_irq_mask(wd_mask),
    .wdog_rank_level(wd_rank)
  );
  tcwu_pin_src u_pin (.clk(clk), .mode(pin_mode), .pin_q(pin));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [9:0] ix,
                     input logic [15:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    // reads just after an edge see the values sampled at that edge
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n == 16) begin
      fail_count++;
      $display("FAIL apb ready expected 1 seen 0");
    end
    // completion edge: take the answer, then release
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never re-drives in this step
    @(posedge clk);
  endtask

  // request line chosen by number
  function automatic logic irq(input int w);
    return w == 0 ? t1_irq : (w == 1 ? t2_irq : wd_irq);
  endfunction

  // pulses and wave-high cycles over a window
  task automatic count_p(input int w, input int cyc, output int c);
    c = 0;
    h = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (irq(w) === 1'b1) c++;
      if (wave === 1'b1) h++;
    end
    @(posedge clk);
  endtask

  // cycles between two successive pulses
  task automatic gap(input int w, output int d);
    int n;
    n = 0;
    d = 1;
    @(negedge clk);
    while (irq(w) !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    while (irq(w) !== 1'b1 && d < 500) begin
      @(negedge clk);
      d++;
    end
    @(posedge clk);
  endtask

  // stop timer 1, clear its flag, then program it
  task automatic t1(input logic [15:0] a, input logic [15:0] b,
                    input logic [15:0] c);
    apb(1'b1, `TCWU_IDX_T1_CTRL, 16'h4000);
    apb(1'b1, `TCWU_IDX_T1_CNT, 16'h0000);
    apb(1'b1, `TCWU_IDX_T1_CMPA, a);
    apb(1'b1, `TCWU_IDX_T1_CMPB, b);
    apb(1'b1, `TCWU_IDX_T1_CTRL, c);
  endtask

  // verdict and end of run
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test;
  end

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    pin_mode = 2'h1;
    rows[0] = '{`TCWU_IDX_T1_CMPA, 16'h1234, 16'h1234, 1'b0};
    rows[1] = '{`TCWU_IDX_T1_CMPB, 16'habcd, 16'habcd, 1'b0};
    rows[2] = '{`TCWU_IDX_T2_CMPA, 16'h0055, 16'h0055, 1'b0};
    rows[3] = '{`TCWU_IDX_T1_CNT, 16'h0102, 16'h0102, 1'b0};
    rows[4] = '{`TCWU_IDX_T2_CNT, 16'h0201, 16'h0201, 1'b0};
    rows[5] = '{`TCWU_IDX_T1_CTRL, 16'h8000, 16'h0000, 1'b0};
    rows[6] = '{`TCWU_IDX_T1_CTRL, 16'h6000, 16'h2000, 1'b0};
    rows[7] = '{`TCWU_IDX_T2_CTRL, 16'ha001, 16'h2001, 1'b0};
    rows[8] = '{`TCWU_IDX_WDOG_CTRL, 16'h0005, 16'h0005, 1'b0};
    rows[9] = '{10'h3ff, 16'h1234, 16'h0000, 1'b1};
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk("wave", 1, wave);
    chk("mask", 1, wd_mask);
    chk("rank", 7, wd_rank);
    // count and compare both zero: a disabled timer still flags max
    repeat (8) @(posedge clk);
    apb(1'b0, `TCWU_IDX_T1_CTRL, 16'h0000);
    chk("t1 ctrl", 32'h0000_0020, rd);
    apb(1'b0, `TCWU_IDX_T2_CTRL, 16'h0000);
    chk("t2 ctrl", 32'h0000_0020, rd);
    apb(1'b0, `TCWU_IDX_WDOG_CTRL, 16'h0000);
    chk("wdog ctrl", 32'h0000_000f, rd);
    $display("test reset ended");
    // register rows: write, read back
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd);
      apb(1'b0, rows[i].idx, 16'h0000);
      chk("reg data", {16'h0000, rows[i].exp}, rd);
      chk("reg err", rows[i].err, err);
    end
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, `TCWU_IDX_WDOG_CTRL, {13'h0000, 3'(r)});
      chk("rank port", r, wd_rank);
      chk("mask port", 0, wd_mask);
    end
    apb(1'b1, `TCWU_IDX_WDOG_CTRL, 16'h000f);
    $display("test registers ended");
    // single mode, four-clock ticks, watchdog masked
    t1(16'h0003, 16'h0009, 16'he001);
    gap(0, g);
    chk("single gap", 16, g);
    count_p(2, 64, p);
    chk("masked wdog", 0, p);
    chk("wave high", 48, h);
    apb(1'b0, `TCWU_IDX_T1_CTRL, 16'h0000);
    chk("t1 flags", 32'h0000_a021, rd);
    t1(16'h0003, 16'h0009, 16'hc001);
    count_p(0, 64, p);
    chk("no int", 0, p);
    t1(16'h0003, 16'h0009, 16'he000);
    count_p(0, 80, p);
    chk("one shot", 1, p);
    apb(1'b0, `TCWU_IDX_T1_CTRL, 16'h0000);
    chk("one shot ctrl", 32'h0000_2020, rd);
    $display("test single ended");
    // dual mode: intervals 12 and 24
    t1(16'h0002, 16'h0005, 16'he003);
    gap(0, g);
    chk("dual gap", 1, g == 12 || g == 24);
    count_p(0, 360, p);
    chk("dual pulses", 20, p);
    chk("dual wave", 120, h);
    $display("test dual ended");
    // chained through timer 2
    apb(1'b1, `TCWU_IDX_T2_CNT, 16'h0000);
    apb(1'b1, `TCWU_IDX_T2_CMPA, 16'h0001);
    apb(1'b1, `TCWU_IDX_T2_CTRL, 16'he001);
    t1(16'h0001, 16'h0009, 16'he009);
    count_p(1, 64, p);
    chk("t2 pulses", 8, p);
    count_p(0, 64, p);
    chk("chain pulses", 4, p);
    apb(1'b1, `TCWU_IDX_T2_CTRL, 16'h4000);
    $display("test chain ended");
    // outside clock, retrigger and prescale ignored
    pin_mode <= 2'h2;
    t1(16'h0001, 16'h0009, 16'he005);
    count_p(0, 128, p);
    chk("ext pulses", 4, p);
    t1(16'h0001, 16'h0009, 16'he01d);
    count_p(0, 128, p);
    chk("ext rtg pulses", 4, p);
    // retrigger clears count on every rise, max never reached
    t1(16'h0003, 16'h0009, 16'he011);
    count_p(0, 128, p);
    chk("retrig pulses", 0, p);
    // gated by the pin level
    pin_mode <= 2'h0;
    t1(16'h0003, 16'h0009, 16'he001);
    count_p(0, 64, p);
    chk("gated low", 0, p);
    pin_mode <= 2'h1;
    gap(0, g);
    chk("gated high", 16, g);
    $display("test pin ended");
    // watchdog: timer first, unmask after, reload in time
    t1(16'h00ff, 16'h0000, 16'he001);
    apb(1'b1, `TCWU_IDX_WDOG_CTRL, 16'h0007);
    q = 0;
    repeat (5) begin
      count_p(2, 200, p);
      q += p;
      apb(1'b1, `TCWU_IDX_T1_CNT, 16'h0000);
    end
    chk("wdog quiet", 0, q);
    count_p(2, 1100, p);
    chk("wdog fires", 1, p == 1 || p == 2);
    $display("test watchdog ended");
    finish_test;
  end
endmodule

// [pkg/tcwu_defines.svh]
`ifndef TCWU_DEFINES_SVH
`define TCWU_DEFINES_SVH

// register indices; byte address is four times the index
`define TCWU_IDX_WDOG_CTRL 10'h042
`define TCWU_IDX_T1_CNT 10'h058
`define TCWU_IDX_T1_CMPA 10'h05a
`define TCWU_IDX_T1_CMPB 10'h05c
`define TCWU_IDX_T1_CTRL 10'h05e
`define TCWU_IDX_T2_CNT 10'h060
`define TCWU_IDX_T2_CMPA 10'h062
`define TCWU_IDX_T2_CTRL 10'h066

// mode/control field positions
`define TCWU_BIT_EN 15
`define TCWU_BIT_WG 14
`define TCWU_BIT_INT 13
`define TCWU_BIT_CSEL 12
`define TCWU_BIT_MC 5
`define TCWU_BIT_RTG 4
`define TCWU_BIT_CHAIN 3
`define TCWU_BIT_OCLK 2
`define TCWU_BIT_DUAL 1
`define TCWU_BIT_RUN 0
`define TCWU_BIT_WD_MASK 3

// reset values
`define TCWU_CNT_RST 16'h0000
`define TCWU_WD_MASK_RST 1'b1
`define TCWU_WD_RANK_RST 3'h7

// last phase of the four-clock count divider
`define TCWU_DIV_LAST 2'h3

`endif

// [pkg/tcwu_pkg.sv]
package tcwu_pkg;

  // apb answer phase
  typedef enum logic [0:0] {
    TCWU_BUS_IDLE = 1'b0,
    TCWU_BUS_ANSWER = 1'b1
  } tcwu_bus_e;

  // one timer's stored mode/control bits
  typedef struct packed {
    logic en;          // counting enabled
    logic irq_en;      // interrupt on max count
    logic cmp_b_sel;   // compare b is the active max
    logic maxcnt;      // max count reached, sticky
    logic retrig;      // restart on input rising edge
    logic chain;       // tick from timer 2
    logic outside_clk; // tick from input pin
    logic dual;        // dual compare mode
    logic repeat_run;  // keep running after max
  } tcwu_ctrl_s;

  // result of one counting step
  typedef struct packed {
    logic [15:0] count;
    logic hit;
  } tcwu_step_s;

  // tick generator state
  typedef struct packed {
    logic [1:0] div;
    logic [1:0] ext_div;
    logic pin_prev;
  } tcwu_tick_s;

  // whole state of the timer unit
  typedef struct packed {
    tcwu_bus_e bus;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    tcwu_ctrl_s t1;
    logic [15:0] t1_cnt;
    logic [15:0] t1_cmpa;
    logic [15:0] t1_cmpb;
    tcwu_ctrl_s t2;
    logic [15:0] t2_cnt;
    logic [15:0] t2_cmpa;
    logic wd_mask;
    logic [2:0] wd_rank;
    logic t1_irq;
    logic t2_irq;
    logic wd_irq;
    logic t1_out;
  } tcwu_state_s;

  // one step: hit when a tick finds the count at max, then wrap or add
  function automatic tcwu_step_s tcwu_step(input logic [15:0] cnt,
                                           input logic [15:0] maxv,
                                           input logic tick,
                                           input logic run);
    tcwu_step_s r;
    r.hit = tick && (cnt == maxv);
    r.count = cnt;
    if (tick && run) begin
      r.count = r.hit ? 16'h0000 : 16'(cnt + 16'h0001);
    end
    return r;
  endfunction

endpackage

// [pkg/tcwu_tick_if.sv]
`timescale 1ns/1ps
// ticks from the divider and pin front end to the timers
interface tcwu_tick_if;
  logic int_tick;  // one clock in four
  logic ext_tick;  // every fourth input rising edge
  logic pin_rise;  // input rising edge
  logic pin_level; // input level
  modport src (output int_tick, output ext_tick, output pin_rise,
               output pin_level);
  modport dst (input int_tick, input ext_tick, input pin_rise,
               input pin_level);
endinterface

// [verilog/tcwu_tick.sv]
`timescale 1ns/1ps
`include "tcwu_defines.svh"
module tcwu_tick (
  input wire logic clk,          // processor clock
  input wire logic arst_n,       // async reset, low
  input wire logic timer1_input, // timer 1 input pin
  tcwu_tick_if.src tk            // ticks out
);
  import tcwu_pkg::*;

  tcwu_tick_s q; // registered state
  tcwu_tick_s d; // next state

  // tick and edge outputs
  assign tk.pin_level = timer1_input;
  assign tk.pin_rise = timer1_input & ~q.pin_prev;
  assign tk.int_tick = (q.div == `TCWU_DIV_LAST);
  assign tk.ext_tick = tk.pin_rise && (q.ext_div == `TCWU_DIV_LAST);

  // free divider and input edge counter
  always_comb begin
    d = q;
    d.div = 2'(q.div + 2'h1);
    d.pin_prev = timer1_input;
    if (tk.pin_rise) begin // count input edges
      d.ext_div = 2'(q.ext_div + 2'h1);
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // internal tick every fourth clock
  sequence four_clk_gap;
    tk.int_tick ##1 !tk.int_tick [*3] ##1 tk.int_tick;
  endsequence
  int_tick_period_a: assert property (@(posedge clk) disable iff (!arst_n)
    tk.int_tick |-> four_clk_gap)
    else $error("internal tick not every four clocks");
endmodule

// [verilog/tcwu_top.sv]
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "tcwu_defines.svh"
// Overview of operation
// - ext0 rtg0: count only while input high
// - ext0 rtg1: count, clear on input rise
// - ext1: count every fourth input rising edge
// - ext0 p0: count every four clocks
// - ext0 p1: count on timer 2 tick
// - dual: alternate compare a and b
// - single: wrap at compare a only
// - no repeat: stop and clear enable
// - enable writes take effect only with write guard set
// - write guard never stored, reads zero
// - interrupt at max count when enabled
// - max flag set even when disabled
// - timer 2: compare a, four-clock ticks
// - count registers readable and reloadable
// - mask bit blocks watchdog interrupt
// - priority field binary, zero highest
// - select flag shows active compare
// - dual mode interrupts at both compares
module tcwu_top (
  input wire logic clk,                 // 40 MHz processor clock
  input wire logic arst_n,              // async reset, low
  input wire logic psel,                // apb select
  input wire logic penable,             // apb access phase
  input wire logic pwrite,              // apb write
  input wire logic [11:0] paddr,        // apb byte address
  input wire logic [31:0] pwdata,       // apb write data
  input wire logic [3:0] pstrb,         // apb byte strobes
  output logic pready,                  // apb ready
  output logic [31:0] prdata,           // apb read data
  output logic pslverr,                 // apb error, unmapped
  input wire logic timer1_input,        // timer 1 input pin
  output logic timer1_wave_out,         // timer 1 output pin
  output logic timer1_irq,              // timer 1 request pulse
  output logic timer2_irq,              // timer 2 request pulse
  output logic wdog_irq_req,            // watchdog request pulse
  output logic wdog_irq_mask,           // watchdog mask level
  output logic [2:0] wdog_rank_level    // watchdog priority
);
  import tcwu_pkg::*;

  tcwu_state_s q; // registered state
  tcwu_state_s d; // next state

  tcwu_tick_if tk (); // ticks from the front end

  tcwu_step_s st1;     // timer 1 step
  tcwu_step_s st2;     // timer 2 step
  logic t2_pre;        // prescaled tick to timer 1
  logic t1_src;        // internal source of timer 1
  logic t1_tick;       // timer 1 counting tick
  logic [15:0] t1_max; // active max count
  logic clr1;          // retrigger clear
  logic acc;           // apb access completes
  logic wr;            // apb write completes
  logic [9:0] idx;     // register index
  logic [15:0] wv;     // merged write value

  // front end: divider and input edges
  tcwu_tick u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .timer1_input(timer1_input),
    .tk(tk)
  );

  // pack a control register for reading; guard bit always zero
  function automatic logic [15:0] tcwu_pack(input tcwu_ctrl_s c);
    logic [15:0] r;
    r = 16'h0000;
    r[`TCWU_BIT_EN] = c.en;
    r[`TCWU_BIT_INT] = c.irq_en;
    r[`TCWU_BIT_CSEL] = c.cmp_b_sel;
    r[`TCWU_BIT_MC] = c.maxcnt;
    r[`TCWU_BIT_RTG] = c.retrig;
    r[`TCWU_BIT_CHAIN] = c.chain;
    r[`TCWU_BIT_OCLK] = c.outside_clk;
    r[`TCWU_BIT_DUAL] = c.dual;
    r[`TCWU_BIT_RUN] = c.repeat_run;
    return r;
  endfunction

  // merge write data into old value by byte strobes
  function automatic logic [15:0] tcwu_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // read value of a register; unmapped reads zero
  function automatic logic [15:0] tcwu_read(input logic [9:0] i,
                                            input tcwu_state_s s);
    logic [15:0] r;
    r = 16'h0000;
    case (i)
      `TCWU_IDX_WDOG_CTRL: r = {12'h000, s.wd_mask, s.wd_rank};
      `TCWU_IDX_T1_CNT: r = s.t1_cnt;
      `TCWU_IDX_T1_CMPA: r = s.t1_cmpa;
      `TCWU_IDX_T1_CMPB: r = s.t1_cmpb;
      `TCWU_IDX_T1_CTRL: r = tcwu_pack(s.t1);
      `TCWU_IDX_T2_CNT: r = s.t2_cnt;
      `TCWU_IDX_T2_CMPA: r = s.t2_cmpa;
      `TCWU_IDX_T2_CTRL: r = tcwu_pack(s.t2);
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  // address decode for the error answer
  function automatic logic tcwu_mapped(input logic [9:0] i);
    case (i)
      `TCWU_IDX_WDOG_CTRL, `TCWU_IDX_T1_CNT, `TCWU_IDX_T1_CMPA,
      `TCWU_IDX_T1_CMPB, `TCWU_IDX_T1_CTRL, `TCWU_IDX_T2_CNT,
      `TCWU_IDX_T2_CMPA, `TCWU_IDX_T2_CTRL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // bus decode
  assign idx = paddr[11:2];
  assign acc = psel & penable & q.pready;
  assign wr = acc & pwrite;
  assign wv = tcwu_merge(tcwu_read(idx, q), pwdata, pstrb);

  // timer 2 counts internal ticks against compare a only
  assign st2 = tcwu_step(q.t2_cnt, q.t2_cmpa, tk.int_tick, q.t2.en);
  assign t2_pre = st2.hit & q.t2.en;

  // timer 1 source selection
  assign t1_src = q.t1.chain ? t2_pre : tk.int_tick;
  assign t1_tick = q.t1.outside_clk ? tk.ext_tick :
                   (t1_src & (q.t1.retrig | tk.pin_level));
  assign t1_max = (q.t1.dual & q.t1.cmp_b_sel) ? q.t1_cmpb :
                  q.t1_cmpa;
  assign st1 = tcwu_step(q.t1_cnt, t1_max, t1_tick, q.t1.en);
  assign clr1 = q.t1.en & ~q.t1.outside_clk & q.t1.retrig &
                tk.pin_rise;

  // next state
  always_comb begin
    d = q;
    d.t1_irq = 1'b0;
    d.t2_irq = 1'b0;
    d.wd_irq = 1'b0;
    // timer 2 counting
    d.t2_cnt = st2.count;
    if (t2_pre) begin
      d.t2_irq = q.t2.irq_en;
      if (!q.t2.repeat_run) begin
        d.t2.en = 1'b0;
      end
    end
    // timer 1 counting, retrigger wins over the step
    d.t1_cnt = clr1 ? `TCWU_CNT_RST : st1.count;
    if (st1.hit && q.t1.en) begin
      d.t1_irq = q.t1.irq_en;
      d.wd_irq = q.t1.irq_en & ~q.wd_mask;
      d.t1.cmp_b_sel = q.t1.dual & ~q.t1.cmp_b_sel;
      if (!q.t1.repeat_run) begin
        d.t1.en = 1'b0;
      end
    end
    // apb answer phase: ready one cycle after setup
    case (q.bus)
      TCWU_BUS_IDLE: begin
        d.pready = 1'b0;
        if (psel && !penable) begin
          d.bus = TCWU_BUS_ANSWER;
          d.pready = 1'b1;
          d.pslverr = ~tcwu_mapped(idx);
          d.prdata = pwrite ? 32'h0000_0000 :
                     {16'h0000, tcwu_read(idx, q)};
        end
      end
      TCWU_BUS_ANSWER: begin
        if (acc) begin
          d.bus = TCWU_BUS_IDLE;
          d.pready = 1'b0;
          d.pslverr = 1'b0;
        end
      end
      default: begin
        d.bus = TCWU_BUS_IDLE;
        d.pready = 1'b0;
      end
    endcase
    // register writes; software wins over counting
    if (wr) begin
      case (idx)
        `TCWU_IDX_WDOG_CTRL: begin
          d.wd_mask = wv[`TCWU_BIT_WD_MASK];
          d.wd_rank = wv[2:0];
        end
        `TCWU_IDX_T1_CNT: d.t1_cnt = wv;
        `TCWU_IDX_T1_CMPA: d.t1_cmpa = wv;
        `TCWU_IDX_T1_CMPB: d.t1_cmpb = wv;
        `TCWU_IDX_T1_CTRL: begin
          if (wv[`TCWU_BIT_WG]) begin
            d.t1.en = wv[`TCWU_BIT_EN];
          end
          d.t1.irq_en = wv[`TCWU_BIT_INT];
          d.t1.maxcnt = wv[`TCWU_BIT_MC];
          d.t1.retrig = wv[`TCWU_BIT_RTG];
          d.t1.chain = wv[`TCWU_BIT_CHAIN];
          d.t1.outside_clk = wv[`TCWU_BIT_OCLK];
          d.t1.dual = wv[`TCWU_BIT_DUAL];
          d.t1.repeat_run = wv[`TCWU_BIT_RUN];
        end
        `TCWU_IDX_T2_CNT: d.t2_cnt = wv;
        `TCWU_IDX_T2_CMPA: d.t2_cmpa = wv;
        `TCWU_IDX_T2_CTRL: begin
          if (wv[`TCWU_BIT_WG]) begin
            d.t2.en = wv[`TCWU_BIT_EN];
          end
          d.t2.irq_en = wv[`TCWU_BIT_INT];
          d.t2.maxcnt = wv[`TCWU_BIT_MC];
          d.t2.repeat_run = wv[`TCWU_BIT_RUN];
        end
        default: begin
        end
      endcase
    end
    // single mode always uses compare a
    if (!d.t1.dual) begin
      d.t1.cmp_b_sel = 1'b0;
    end
    // max flags: hardware set wins over a clear
    if (st1.hit) begin
      d.t1.maxcnt = 1'b1;
    end
    if (st2.hit) begin
      d.t2.maxcnt = 1'b1;
    end
    // output wave
    if (d.t1.dual) begin
      d.t1_out = ~d.t1.cmp_b_sel;
    end else if (st1.hit && q.t1.en) begin
      d.t1_out = 1'b0;
    end else if (t1_tick) begin
      d.t1_out = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.bus <= TCWU_BUS_IDLE;
      q.t1_out <= 1'b1;
      q.wd_mask <= `TCWU_WD_MASK_RST;
      q.wd_rank <= `TCWU_WD_RANK_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign timer1_wave_out = q.t1_out;
  assign timer1_irq = q.t1_irq;
  assign timer2_irq = q.t2_irq;
  assign wdog_irq_req = q.wd_irq;
  assign wdog_irq_mask = q.wd_mask;
  assign wdog_rank_level = q.wd_rank;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic wr_t1c;  // write to timer 1 count
  logic wr_t1m;  // write to timer 1 control
  assign wr_t1c = wr && (idx == `TCWU_IDX_T1_CNT);
  assign wr_t1m = wr && (idx == `TCWU_IDX_T1_CTRL);

  // setup then answer with guard bit clear
  sequence ctrl_setup;
    psel && !penable && !pwrite &&
    (idx == `TCWU_IDX_T1_CTRL || idx == `TCWU_IDX_T2_CTRL);
  endsequence
  guard_reads_zero_a: assert property (
    ctrl_setup |=> pready && !prdata[`TCWU_BIT_WG])
    else $error("guard bit read back non-zero");
  enable_guard_a: assert property (
    (wr_t1m && !wv[`TCWU_BIT_WG] && !st1.hit) |=> $stable(q.t1.en))
    else $error("enable changed without guard");
  hold_low_a: assert property (
    (q.t1.en && !q.t1.outside_clk && !q.t1.retrig && !tk.pin_level &&
     !wr) |=> $stable(q.t1_cnt))
    else $error("count moved with input low");
  retrig_clear_a: assert property (
    (clr1 && !wr_t1c) |=> (q.t1_cnt == 16'h0000))
    else $error("retrigger did not clear count");
  ext_hold_a: assert property (
    (q.t1.en && q.t1.outside_clk && !tk.ext_tick && !wr) |=>
    $stable(q.t1_cnt))
    else $error("count moved without fourth input edge");
  inc_step_a: assert property (
    (t1_tick && q.t1.en && !st1.hit && !clr1 && !wr_t1c) |=>
    (q.t1_cnt == 16'($past(q.t1_cnt) + 16'h0001)))
    else $error("count did not advance by one");
  chain_hold_a: assert property (
    (q.t1.en && !q.t1.outside_clk && q.t1.chain && !t2_pre && !clr1 &&
     !wr) |=> $stable(q.t1_cnt))
    else $error("chained count moved without timer 2 tick");
  dual_toggle_a: assert property (
    (q.t1.en && q.t1.dual && st1.hit && !wr) |=>
    (q.t1.cmp_b_sel != $past(q.t1.cmp_b_sel)))
    else $error("active compare did not alternate");
  single_wrap_a: assert property (
    (q.t1.en && !q.t1.dual && t1_tick && (q.t1_cnt == q.t1_cmpa) &&
     !wr) |=> (q.t1_cnt == 16'h0000) && !q.t1.cmp_b_sel)
    else $error("single mode did not wrap at compare a");
  halt_a: assert property (
    (q.t1.en && !q.t1.repeat_run && st1.hit && !wr_t1m) |=> !q.t1.en)
    else $error("timer kept running without repeat");
  irq_a: assert property (
    (st1.hit && q.t1.en) |=> (timer1_irq == $past(q.t1.irq_en)))
    else $error("interrupt not tied to max count");
  maxflag_a: assert property (
    st1.hit |=> q.t1.maxcnt)
    else $error("timer 1 max flag not set");
  t2_maxflag_a: assert property (
    st2.hit |=> q.t2.maxcnt)
    else $error("timer 2 max flag not set");
  wdog_mask_a: assert property (
    wdog_irq_req |-> !$past(q.wd_mask) && timer1_irq)
    else $error("masked watchdog raised a request");
endmodule
